/* File: rtl/tai_pkg.sv */
// constants and types for the temperature alarm and interrupt logic
package tai_pkg;
    // register data and address width
    localparam int REG_W = 8;
    localparam int NCH   = 2;
    localparam int CH_LOC = 0;
    localparam int CH_REM = 1;

    // read addresses
    localparam logic [7:0] ADR_LOC_TEMP  = 8'h00;
    localparam logic [7:0] ADR_REM_TEMP  = 8'h01;
    localparam logic [7:0] ADR_STATUS    = 8'h02;
    localparam logic [7:0] ADR_CFG_RD    = 8'h03;
    localparam logic [7:0] ADR_LOC_HI_RD = 8'h05;
    localparam logic [7:0] ADR_LOC_LO_RD = 8'h06;
    localparam logic [7:0] ADR_REM_HI_RD = 8'h07;
    localparam logic [7:0] ADR_REM_LO_RD = 8'h08;
    // write addresses
    localparam logic [7:0] ADR_CFG_WR    = 8'h09;
    localparam logic [7:0] ADR_LOC_HI_WR = 8'h0b;
    localparam logic [7:0] ADR_LOC_LO_WR = 8'h0c;
    localparam logic [7:0] ADR_REM_HI_WR = 8'h0d;
    localparam logic [7:0] ADR_REM_LO_WR = 8'h0e;
    localparam logic [7:0] ADR_ONE_SHOT  = 8'h0f;
    // shared read and write addresses
    localparam logic [7:0] ADR_REM_TRIP  = 8'h19;
    localparam logic [7:0] ADR_LOC_TRIP  = 8'h20;
    localparam logic [7:0] ADR_HYST      = 8'h21;

    // reset values
    localparam logic [7:0] RST_HI   = 8'h55;
    localparam logic [7:0] RST_LO   = 8'h00;
    localparam logic [7:0] RST_TRIP = 8'h55;
    localparam logic [7:0] RST_HYST = 8'h0a;
    localparam logic [7:0] RST_CFG  = 8'h00;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // configuration bits
    localparam int CFG_MASK_BIT  = 7;
    localparam int CFG_STBY_BIT  = 6;
    localparam int CFG_TRIP2_BIT = 5;
    // status bits
    localparam int ST_LOC_HI = 6;
    localparam int ST_LOC_LO = 5;
    localparam int ST_REM_HI = 4;
    localparam int ST_REM_LO = 3;
    localparam int ST_OPEN   = 2;

    localparam logic ARA_LSB = 1'b1;

    typedef enum logic [1:0] {
        K_WR   = 2'b00,
        K_RD   = 2'b01,
        K_ARA  = 2'b10,
        K_DONE = 2'b11
    } tai_kind_e;

    typedef enum logic {
        CV_IDLE = 1'b0,
        CV_RUN  = 1'b1
    } tai_conv_e;
endpackage

/* File: rtl/tai_alarm.sv */
// alarm, thermal trip, standby and one-shot logic of a temperature monitor
`timescale 1ns/100ps
module tai_alarm #(
    parameter logic [6:0] DEV_ADDR = 7'h2a // arbitrary value
) (
    // system
    input  wire logic                       mclk,
    input  wire logic                       rstn,
    input  wire logic                       ce,
    // serial bus side, link clock domain
    input  wire logic                       smb_clk,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    input  wire logic                       ara_rd,
    input  wire logic                       ara_done,
    input  wire logic                       ara_lost,
    input  wire logic [tai_pkg::REG_W-1:0]  reg_addr,
    input  wire logic [tai_pkg::REG_W-1:0]  reg_wdata,
    output logic                            smb_busy,
    output logic                            rsp_valid,
    output logic                            rsp_ack,
    output logic [tai_pkg::REG_W-1:0]       rsp_data,
    // converter
    output logic                            conv_start,
    output logic                            conv_abort,
    input  wire logic                       conv_done,
    input  wire logic [tai_pkg::REG_W-1:0]  loc_temp_in,
    input  wire logic [tai_pkg::REG_W-1:0]  rem_temp_in,
    input  wire logic                       open_diode,
    // open-drain pins
    output logic                            alert_o,
    output logic                            alert_oe_n,
    output logic                            thermal_trip_o,
    output logic                            thermal_trip_oe_n
);
    import tai_pkg::*;

    // link domain
    logic             srst_a_q, srst_b_q;
    logic             busy_q, req_tgl_q, rsp_valid_q, rsp_ack_q;
    logic [REG_W-1:0] rsp_data_q, addr_q, wdata_q;
    tai_kind_e        kind_q;
    logic             ack_s1_q, ack_s2_q, ack_s3_q;
    // system domain
    logic             req_s1_q, req_s2_q, req_s3_q, ack_tgl_q;
    logic [REG_W-1:0] rdata_m_q;
    logic             ack_m_q;
    logic             open_s1_q, open_s2_q, open_s3_q, open_q;
    logic             cmd_evt;
    logic [REG_W-1:0] cfg_q, status_q, hyst_q, st_set, rdata_d;
    logic [REG_W-1:0] temp_q [NCH];
    logic [REG_W-1:0] hi_q   [NCH];
    logic [REG_W-1:0] lo_q   [NCH];
    logic [REG_W-1:0] trip_q [NCH];
    logic [NCH-1:0]   hi_v, lo_v, trip_set, trip_rel, t2_set, t2_rel;
    logic [NCH-1:0]   trip_act_q, t2_act_q;
    tai_conv_e        conv_q;
    logic             oneshot_q, eval_q, conv_start_q, conv_abort_q;
    logic             alert_q, alert_oe_n_q, trip_oe_n_q;
    logic             standby, trip2_mode, masked, wr_evt, rd_evt;
    logic             ara_evt, done_evt, rel_ok, lim_wr;

    assign cmd_evt    = req_s2_q ^ req_s3_q;
    assign wr_evt     = cmd_evt && kind_q == K_WR;
    assign rd_evt     = cmd_evt && kind_q == K_RD;
    assign ara_evt    = cmd_evt && kind_q == K_ARA;
    assign done_evt   = cmd_evt && kind_q == K_DONE;
    assign standby    = cfg_q[CFG_STBY_BIT];
    assign trip2_mode = cfg_q[CFG_TRIP2_BIT];
    assign masked     = cfg_q[CFG_MASK_BIT];

    // link clock may stop between frames; reset is re-timed onto it
    always_ff @(posedge smb_clk) begin
        srst_a_q <= rstn;
        srst_b_q <= srst_a_q;
    end

    always_ff @(posedge smb_clk) begin
        if (!srst_b_q) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            ack_s3_q <= 1'b0;
        end else begin
            ack_s1_q <= ack_tgl_q;
            ack_s2_q <= ack_s1_q;
            ack_s3_q <= ack_s2_q;
        end
    end

    // one request in flight; fields stay stable until the answer returns
    always_ff @(posedge smb_clk) begin
        if (!srst_b_q) begin
            busy_q      <= 1'b0;
            req_tgl_q   <= 1'b0;
            kind_q      <= K_WR;
            addr_q      <= RST_ZERO;
            wdata_q     <= RST_ZERO;
            rsp_valid_q <= 1'b0;
            rsp_ack_q   <= 1'b0;
            rsp_data_q  <= RST_ZERO;
        end else begin
            rsp_valid_q <= 1'b0;
            if (!busy_q && (reg_wr || reg_rd || ara_rd || ara_done)) begin
                busy_q    <= 1'b1;
                req_tgl_q <= ~req_tgl_q;
                addr_q    <= reg_addr;
                wdata_q   <= reg_wdata;
                if (reg_wr) begin
                    kind_q <= K_WR;
                end else if (reg_rd) begin
                    kind_q <= K_RD;
                end else if (ara_rd) begin
                    kind_q <= K_ARA;
                end else begin
                    kind_q     <= K_DONE;
                    wdata_q[0] <= ara_lost;
                end
            end
            if (busy_q && (ack_s2_q != ack_s3_q)) begin
                busy_q      <= 1'b0;
                rsp_valid_q <= 1'b1;
                rsp_ack_q   <= ack_m_q;
                rsp_data_q  <= rdata_m_q;
            end
        end
    end

    assign smb_busy  = busy_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp_ack   = rsp_ack_q;
    assign rsp_data  = rsp_data_q;

    // request toggle and diode comparator enter through three flops
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            req_s1_q  <= 1'b0;
            req_s2_q  <= 1'b0;
            req_s3_q  <= 1'b0;
            open_s1_q <= 1'b0;
            open_s2_q <= 1'b0;
            open_s3_q <= 1'b0;
            open_q    <= 1'b0;
        end else if (ce) begin
            req_s1_q  <= req_tgl_q;
            req_s2_q  <= req_s1_q;
            req_s3_q  <= req_s2_q;
            open_s1_q <= open_diode;
            open_s2_q <= open_s1_q;
            open_s3_q <= open_s2_q;
            if (open_s2_q == open_s3_q) begin
                open_q <= open_s3_q;
            end
        end
    end

    // configuration, limits and hysteresis stay writable in standby
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cfg_q          <= RST_CFG;
            hyst_q         <= RST_HYST;
            hi_q[CH_LOC]   <= RST_HI;
            hi_q[CH_REM]   <= RST_HI;
            lo_q[CH_LOC]   <= RST_LO;
            lo_q[CH_REM]   <= RST_LO;
            trip_q[CH_LOC] <= RST_TRIP;
            trip_q[CH_REM] <= RST_TRIP;
        end else if (ce && wr_evt) begin
            unique case (addr_q)
                ADR_CFG_WR:    cfg_q          <= wdata_q;
                ADR_LOC_HI_WR: hi_q[CH_LOC]   <= wdata_q;
                ADR_LOC_LO_WR: lo_q[CH_LOC]   <= wdata_q;
                ADR_REM_HI_WR: hi_q[CH_REM]   <= wdata_q;
                ADR_REM_LO_WR: lo_q[CH_REM]   <= wdata_q;
                ADR_REM_TRIP:  trip_q[CH_REM] <= wdata_q;
                ADR_LOC_TRIP:  trip_q[CH_LOC] <= wdata_q;
                ADR_HYST:      hyst_q         <= wdata_q;
                default: ;
            endcase
        end
    end

    assign lim_wr = wr_evt && (addr_q == ADR_LOC_HI_WR
        || addr_q == ADR_LOC_LO_WR || addr_q == ADR_REM_HI_WR
        || addr_q == ADR_REM_LO_WR);

    // conversion sequencer; one-shot address holds no data
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            conv_q       <= CV_IDLE;
            oneshot_q    <= 1'b0;
            conv_start_q <= 1'b0;
            conv_abort_q <= 1'b0;
            eval_q       <= 1'b0;
            temp_q[CH_LOC] <= RST_ZERO;
            temp_q[CH_REM] <= RST_ZERO;
        end else if (ce) begin
            conv_start_q <= 1'b0;
            conv_abort_q <= 1'b0;
            eval_q       <= standby && lim_wr;
            if (wr_evt && addr_q == ADR_ONE_SHOT && standby) begin
                oneshot_q <= 1'b1;
            end
            unique case (conv_q)
                CV_IDLE: begin
                    if (!standby || oneshot_q) begin
                        conv_q       <= CV_RUN;
                        conv_start_q <= 1'b1;
                    end
                end
                CV_RUN: begin
                    if (standby && !oneshot_q) begin
                        // result of an aborted run never lands
                        conv_q       <= CV_IDLE;
                        conv_abort_q <= 1'b1;
                    end else if (conv_done) begin
                        conv_q         <= CV_IDLE;
                        oneshot_q      <= 1'b0;
                        temp_q[CH_LOC] <= loc_temp_in;
                        temp_q[CH_REM] <= rem_temp_in;
                        eval_q         <= 1'b1;
                    end
                end
            endcase
        end
    end

    assign conv_start = conv_start_q;
    assign conv_abort = conv_abort_q;

    // per-channel limit and trip comparisons with hysteresis
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        assign hi_v[c]     = temp_q[c] > hi_q[c];
        assign lo_v[c]     = temp_q[c] <= lo_q[c];
        assign trip_set[c] = temp_q[c] > trip_q[c];
        // sum in nine bits so a large hysteresis cannot wrap
        assign trip_rel[c] = ({1'b0, temp_q[c]} + {1'b0, hyst_q})
                             <= {1'b0, trip_q[c]};
        assign t2_set[c]   = hi_v[c];
        assign t2_rel[c]   = ({1'b0, temp_q[c]} + {1'b0, hyst_q})
                             <= {1'b0, hi_q[c]};
        always_ff @(posedge mclk) begin
            if (!rstn) begin
                trip_act_q[c] <= 1'b0;
                t2_act_q[c]   <= 1'b0;
            end else if (ce) begin
                if (trip_set[c]) begin
                    trip_act_q[c] <= 1'b1;
                end else if (trip_rel[c]) begin
                    trip_act_q[c] <= 1'b0;
                end
                if (t2_set[c]) begin
                    t2_act_q[c] <= 1'b1;
                end else if (t2_rel[c]) begin
                    t2_act_q[c] <= 1'b0;
                end
            end
        end
    end

    // status flags: clear on read, a same-cycle set wins
    always_comb begin
        st_set = RST_ZERO;
        if (eval_q) begin
            st_set[ST_LOC_HI] = hi_v[CH_LOC];
            st_set[ST_LOC_LO] = lo_v[CH_LOC];
            st_set[ST_REM_HI] = hi_v[CH_REM];
            st_set[ST_REM_LO] = lo_v[CH_REM];
        end
        st_set[ST_OPEN] = conv_start_q && open_q;
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            status_q <= RST_ZERO;
        end else if (ce) begin
            if (rd_evt && addr_q == ADR_STATUS) begin
                status_q <= st_set;
            end else begin
                status_q <= status_q | st_set;
            end
        end
    end

    // register read mux
    always_comb begin
        unique case (addr_q)
            ADR_LOC_TEMP:  rdata_d = temp_q[CH_LOC];
            ADR_REM_TEMP:  rdata_d = temp_q[CH_REM];
            ADR_STATUS:    rdata_d = status_q;
            ADR_CFG_RD:    rdata_d = cfg_q;
            ADR_LOC_HI_RD: rdata_d = hi_q[CH_LOC];
            ADR_LOC_LO_RD: rdata_d = lo_q[CH_LOC];
            ADR_REM_HI_RD: rdata_d = hi_q[CH_REM];
            ADR_REM_LO_RD: rdata_d = lo_q[CH_REM];
            ADR_REM_TRIP:  rdata_d = trip_q[CH_REM];
            ADR_LOC_TRIP:  rdata_d = trip_q[CH_LOC];
            ADR_HYST:      rdata_d = hyst_q;
            default:       rdata_d = RST_ZERO;
        endcase
    end

    // answers go back by toggle; data holds until the next request
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ack_tgl_q <= 1'b0;
            ack_m_q   <= 1'b0;
            rdata_m_q <= RST_ZERO;
        end else if (ce && cmd_evt) begin
            ack_tgl_q <= ~ack_tgl_q;
            ack_m_q   <= 1'b1;
            rdata_m_q <= rdata_d;
            if (kind_q == K_ARA) begin
                ack_m_q   <= alert_q && !trip2_mode;
                rdata_m_q <= {DEV_ADDR, ARA_LSB};
            end
        end
    end

    // outside second trip mode, release only after a won answer with flags clear and cause gone
    assign rel_ok = done_evt && !wdata_q[0] && status_q == RST_ZERO
                    && st_set == RST_ZERO && hi_v == '0 && lo_v == '0
                    && !open_q;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            alert_q <= 1'b0;
        end else if (ce) begin
            if (!trip2_mode && !masked && status_q != RST_ZERO) begin
                alert_q <= 1'b1;
            end else if (rel_ok || trip2_mode) begin
                alert_q <= 1'b0;
            end
        end
    end

    // pins only ever pull low or float
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            alert_oe_n_q <= 1'b1;
            trip_oe_n_q  <= 1'b1;
        end else if (ce) begin
            // outside second trip mode the mask hides the pin but keeps the pending alarm
            alert_oe_n_q <= trip2_mode ? ~|t2_act_q
                          : ~(alert_q && !masked);
            trip_oe_n_q  <= ~|trip_act_q;
        end
    end

    assign alert_o           = 1'b0;
    assign alert_oe_n        = alert_oe_n_q;
    assign thermal_trip_o    = 1'b0;
    assign thermal_trip_oe_n = trip_oe_n_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn || !ce);

    property p_alert_pin;
        alert_q && !trip2_mode && !masked |=> !alert_oe_n;
    endproperty
    a_alert_pin: assert property (p_alert_pin)
        else $error("alarm active but pin released");

    property p_od;
        !alert_oe_n |-> !alert_o;
    endproperty
    a_od: assert property (p_od)
        else $error("alarm pin driven high");

    property p_mask;
        masked && !trip2_mode |=> alert_oe_n;
    endproperty
    a_mask: assert property (p_mask)
        else $error("masked alarm pulled the pin");

    property p_ara;
        ara_evt && alert_q && !trip2_mode
            |=> ack_m_q && rdata_m_q == {DEV_ADDR, ARA_LSB};
    endproperty
    a_ara: assert property (p_ara)
        else $error("alert response byte wrong");

    property p_release;
        $fell(alert_q) && !trip2_mode |-> $past(rel_ok);
    endproperty
    a_release: assert property (p_release)
        else $error("alarm released without serviced read");

    property p_abort;
        conv_q == CV_RUN && standby && !oneshot_q
            |=> conv_abort && conv_q == CV_IDLE && !eval_q;
    endproperty
    a_abort: assert property (p_abort)
        else $error("standby did not abort conversion");

    property p_oneshot;
        wr_evt && addr_q == ADR_ONE_SHOT && standby && conv_q == CV_IDLE
            |-> ##[1:3] conv_start;
    endproperty
    a_oneshot: assert property (p_oneshot)
        else $error("one-shot write started no conversion");

    property p_open;
        conv_start && open_q |=> status_q[ST_OPEN];
    endproperty
    a_open: assert property (p_open)
        else $error("open diode flag not set");

    property p_high;
        eval_q && temp_q[CH_LOC] > hi_q[CH_LOC] |=> status_q[ST_LOC_HI];
    endproperty
    a_high: assert property (p_high)
        else $error("high limit violation not flagged");

    property p_trip;
        |trip_set |=> ##1 !thermal_trip_oe_n;
    endproperty
    a_trip: assert property (p_trip)
        else $error("trip output not asserted");

    property p_trip_rel;
        trip_act_q[CH_REM] && !trip_set[CH_REM] && trip_rel[CH_REM]
            |=> !trip_act_q[CH_REM];
    endproperty
    a_trip_rel: assert property (p_trip_rel)
        else $error("trip not released after hysteresis");

    property p_reset_vals;
        $rose(rstn) |-> hyst_q == RST_HYST && trip_q[CH_LOC] == RST_TRIP;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("trip defaults wrong");

endmodule // tai_alarm

/* File: verification/tai_conv_model.sv */
// converter stand-in answering conversion starts
`timescale 1ns/100ps
module tai_conv_model #(
    parameter int LAT = 4
) (
    // clock and handshake
    input  wire logic       mclk,
    input  wire logic       conv_start,
    input  wire logic       conv_abort,
    output logic            conv_done,
    // readings
    input  wire logic [7:0] loc_t,
    input  wire logic [7:0] rem_t,
    output logic [7:0]      loc_temp_in,
    output logic [7:0]      rem_temp_in
);
    int cnt = 0;
    initial conv_done = 1'b0;
    // an aborted run never reports
    always @(posedge mclk) begin
        conv_done <= 1'b0;
        if (conv_abort === 1'b1)
            cnt <= 0;
        else if (conv_start === 1'b1)
            cnt <= LAT;
        else if (cnt == 1) begin
            cnt <= 0;
            conv_done <= 1'b1;
        end else if (cnt > 1)
            cnt <= cnt - 1;
    end
    // stale readings shown inverted, never held
    assign loc_temp_in = conv_done ? loc_t : ~loc_t;
    assign rem_temp_in = conv_done ? rem_t : ~rem_t;
endmodule // tai_conv_model

/* File: verification/tai_alarm_bench.sv */
// testbench for the alarm and trip logic
`timescale 1ns/100ps
module tai_alarm_bench;
    import tai_pkg::*;
    localparam logic [6:0] ADDR = 7'h31; // arbitrary value
    logic       mclk = 0, rstn = 0, smb_clk = 0, ce = 1, smb_run = 1;
    logic       reg_wr = 0, reg_rd = 0, ara_rd = 0, ara_done = 0;
    logic       ara_lost = 0, smb_busy, rsp_valid, rsp_ack;
    logic [7:0] reg_addr = 0, reg_wdata = 0, rsp_data;
    logic       conv_start, conv_abort, conv_done, open_diode = 0;
    logic [7:0] loc_temp_in, rem_temp_in, loc_t = 8'h14, rem_t = 8'h14;
    logic       alert_o, alert_oe_n, thermal_trip_o, thermal_trip_oe_n;
    int         fails = 0, comparisons = 0, starts = 0, base = 0;

    always #50 mclk = ~mclk;
    // bus clock idles high between frames
    always #80 if (smb_run || !smb_clk) smb_clk = ~smb_clk;
    always @(posedge mclk) if (conv_start === 1'b1) starts++;

    tai_alarm #(.DEV_ADDR(ADDR)) i_tai_alarm (
        .mclk(mclk), .rstn(rstn), .ce(ce), .smb_clk(smb_clk),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .ara_rd(ara_rd),
        .ara_done(ara_done), .ara_lost(ara_lost), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .smb_busy(smb_busy), .rsp_valid(rsp_valid),
        .rsp_ack(rsp_ack), .rsp_data(rsp_data), .conv_start(conv_start),
        .conv_abort(conv_abort), .conv_done(conv_done),
        .loc_temp_in(loc_temp_in), .rem_temp_in(rem_temp_in),
        .open_diode(open_diode), .alert_o(alert_o),
        .alert_oe_n(alert_oe_n), .thermal_trip_o(thermal_trip_o),
        .thermal_trip_oe_n(thermal_trip_oe_n));
    tai_conv_model i_tai_conv_model (
        .mclk(mclk), .conv_start(conv_start), .conv_abort(conv_abort),
        .conv_done(conv_done), .loc_t(loc_t), .rem_t(rem_t),
        .loc_temp_in(loc_temp_in), .rem_temp_in(rem_temp_in));

    task automatic end_of_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chkb(input string n, input logic e, g);
        chk(n, {7'h0, e}, {7'h0, g});
    endtask
    task automatic settle;
        smb_run = 1'b0;
        repeat (6) @(posedge mclk);
        #1;
    endtask
    // one pulse request, then wait for the answer
    task automatic xfer(input tai_kind_e k, input logic [7:0] a, d);
        int n;
        smb_run = 1'b1;
        @(posedge smb_clk) #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = (k == K_WR);
        reg_rd = (k == K_RD);
        ara_rd = (k == K_ARA);
        ara_done = (k == K_DONE);
        @(posedge smb_clk) #1;
        {reg_wr, reg_rd, ara_rd, ara_done} = 4'h0;
        chkb("busy", 1'b1, smb_busy);
        n = 0;
        while (rsp_valid !== 1'b1 && n < 20) begin
            @(posedge smb_clk) #1;
            n++;
        end
        if (n == 20) chkb("answer", 1'b1, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, e, input string n);
        xfer(K_RD, a, 8'h00);
        chk(n, e, rsp_data);
    endtask
    task automatic wr(input logic [7:0] a, d);
        xfer(K_WR, a, d);
        chkb("wr ack", 1'b1, rsp_ack);
        settle;
    endtask
    // alert read, then the closing byte
    task automatic service(input logic lost);
        xfer(K_ARA, 8'h00, 8'h00);
        chk("ara addr", {ADDR, ARA_LSB}, rsp_data);
        chkb("ara ack", 1'b1, rsp_ack);
        ara_lost = lost;
        xfer(K_DONE, 8'h00, 8'h00);
        ara_lost = 1'b0;
        settle;
    endtask
    // new readings, several conversions pass
    task automatic temps(input logic [7:0] l, r);
        smb_run = 1'b0;
        loc_t = l;
        rem_t = r;
        repeat (30) @(posedge mclk);
        #1;
    endtask

    initial begin
        #500000;
        fails++;
        end_of_test;
    end

    initial begin
        repeat (6) @(posedge mclk);
        #1 rstn = 1'b1;
        temps(8'h14, 8'h14);
        rd(ADR_LOC_TRIP, RST_TRIP, "loc trip");
        rd(ADR_REM_TRIP, RST_TRIP, "rem trip");
        rd(ADR_HYST, RST_HYST, "hyst");
        rd(ADR_ONE_SHOT, 8'h00, "one-shot");
        rd(8'hfd, 8'h00, "unmapped");
        chkb("pin level", 1'b0, alert_o);
        chkb("trip level", 1'b0, thermal_trip_o);
        chkb("idle", 1'b1, alert_oe_n);
        // masked second trip mode: both pins track 85 less 10
        wr(ADR_CFG_WR, 8'ha0);
        temps(8'h56, 8'h56);
        chkb("trip hot", 1'b0, thermal_trip_oe_n);
        chkb("trip2 hot", 1'b0, alert_oe_n);
        temps(8'h4c, 8'h4b);
        chkb("trip hyst", 1'b0, thermal_trip_oe_n);
        chkb("trip2 hyst", 1'b0, alert_oe_n);
        temps(8'h4b, 8'h4b);
        chkb("trip cool", 1'b1, thermal_trip_oe_n);
        chkb("trip2 cool", 1'b1, alert_oe_n);
        // stale flags hold the alarm until fully serviced
        wr(ADR_CFG_WR, 8'h00);
        chkb("held", 1'b0, alert_oe_n);
        service(1'b1);
        chkb("lost", 1'b0, alert_oe_n);
        service(1'b0);
        chkb("no clear", 1'b0, alert_oe_n);
        rd(ADR_STATUS, 8'h50, "status");
        service(1'b0);
        chkb("released", 1'b1, alert_oe_n);
        temps(8'h55, 8'h00);
        chkb("at limits", 1'b0, alert_oe_n);
        chkb("trip at 85", 1'b1, thermal_trip_oe_n);
        rd(ADR_STATUS, 8'h08, "status edge");
        wr(ADR_CFG_WR, 8'h80);
        chkb("masked", 1'b1, alert_oe_n);
        temps(8'h14, 8'h14);
        wr(ADR_CFG_WR, 8'h00);
        rd(ADR_STATUS, 8'h08, "status low");
        service(1'b0);
        chkb("released 2", 1'b1, alert_oe_n);
        xfer(K_ARA, 8'h00, 8'h00);
        chkb("idle ara", 1'b0, rsp_ack);
        // standby: no starts, one-shot runs exactly once
        wr(ADR_CFG_WR, 8'h40);
        base = starts;
        temps(8'h30, 8'h14);
        chk("standby", 8'h00, 8'(starts - base));
        rd(ADR_LOC_TEMP, 8'h14, "held temp");
        wr(ADR_ONE_SHOT, 8'ha5);
        temps(8'h30, 8'h14);
        chk("one-shot", 8'h01, 8'(starts - base));
        rd(ADR_LOC_TEMP, 8'h30, "new temp");
        wr(ADR_LOC_HI_WR, 8'h20);
        chkb("stby limit", 1'b0, alert_oe_n);
        open_diode = 1'b1;
        wr(ADR_ONE_SHOT, 8'h00);
        temps(8'h30, 8'h14);
        rd(ADR_STATUS, 8'h44, "open flag");
        end_of_test;
    end
endmodule // tai_alarm_bench
